// ### design/ddr2_pkg.sv
// constants, field layouts and carrier types shared by the command core
// assumes a single 20 MHz clock domain
package ddr2_pkg;
  // --------------------------------------------------------------------
  // geometry and clock
  // --------------------------------------------------------------------
  localparam int BANKS = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int COL_W = 10;
  localparam int AP_BIT = 10;
  localparam int CNT_W = 6;
  localparam int LAT_MAX = 16;
  localparam int CLK_NS = 50;
  localparam int TRAS_NS = 40;
  localparam int TRTP_NS = 10;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
  // --------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------
  localparam logic [11:0] CFG_OFS = 12'h000;
  localparam logic [11:0] TIM_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam int CL_LSB = 0;
  localparam int AL_LSB = 3;
  localparam int BL8_BIT = 6;
  localparam int WR_LSB = 7;
  localparam int RDQS_BIT = 10;
  localparam int ORG_LSB = 11;
  localparam int TRAS_LSB = 0;
  localparam int TRTP_LSB = 8;
  localparam int OPEN_LSB = 0;
  localparam int APP_LSB = 8;
  localparam int BUSY_BIT = 16;
  localparam int ERR_BIT = 17;
  localparam logic [2:0] CL_RST = 3'h3;
  localparam logic [2:0] AL_RST = 3'h0;
  localparam logic [2:0] WR_RST = 3'h3;
  localparam logic [1:0] ORG_X4 = 2'h0;
  localparam logic [1:0] ORG_X8 = 2'h1;
  localparam logic [1:0] ORG_X16 = 2'h2;

  // least times round up, never below one cycle
  function automatic logic [CNT_W-1:0] cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) c = 1;
    return CNT_W'(c);
  endfunction : cyc_up

  localparam logic [CNT_W-1:0] TRAS_CYC = cyc_up(TRAS_NS);
  localparam logic [CNT_W-1:0] TRTP_CYC = cyc_up(TRTP_NS);

  // --------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cl;
    logic [2:0] al;
    logic bl8;
    logic [2:0] wr;
    logic rdqs_en;
    logic [1:0] org;
    logic [CNT_W-1:0] tras;
    logic [CNT_W-1:0] trtp;
  } cfg_s;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_s;

  typedef struct packed {
    logic valid;
    logic is_wr;
    logic [BA_W-1:0] bank;
    logic [COL_W-1:0] col;
  } burst_s;
endpackage : ddr2_pkg

// ### design/ddr2_regs.sv
// apb slave holding configuration and showing core status
// assumes apb master timing; zero wait states, read data loaded in setup
`timescale 1ns/1ns
module ddr2_regs (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  output ddr2_pkg::cfg_s cfg,
  input wire logic [31:0] status,
  output logic err_clr
);
  import ddr2_pkg::*;

  logic [31:0] prdata_r;
  logic pslverr_r;
  logic mapped;
  logic wr_acc;

  assign mapped = (paddr == CFG_OFS) || (paddr == TIM_OFS) || (paddr == STAT_OFS);
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  // error flag is write-one-to-clear at the status word
  assign err_clr = wr_acc && (paddr == STAT_OFS) && pwdata[ERR_BIT];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= '{cl: CL_RST, al: AL_RST, bl8: 1'b0, wr: WR_RST, rdqs_en: 1'b0,
               org: ORG_X16, tras: TRAS_CYC, trtp: TRTP_CYC};
    end else if (wr_acc && paddr == CFG_OFS) begin
      cfg.cl <= pwdata[CL_LSB +: 3];
      cfg.al <= pwdata[AL_LSB +: 3];
      cfg.bl8 <= pwdata[BL8_BIT];
      cfg.wr <= pwdata[WR_LSB +: 3];
      cfg.rdqs_en <= pwdata[RDQS_BIT];
      cfg.org <= pwdata[ORG_LSB +: 2];
    end else if (wr_acc && paddr == TIM_OFS) begin
      cfg.tras <= pwdata[TRAS_LSB +: CNT_W];
      cfg.trtp <= pwdata[TRTP_LSB +: CNT_W];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_r <= !mapped;
      prdata_r <= 32'h0;
      if (paddr == CFG_OFS) begin
        prdata_r[CL_LSB +: 3] <= cfg.cl;
        prdata_r[AL_LSB +: 3] <= cfg.al;
        prdata_r[BL8_BIT] <= cfg.bl8;
        prdata_r[WR_LSB +: 3] <= cfg.wr;
        prdata_r[RDQS_BIT] <= cfg.rdqs_en;
        prdata_r[ORG_LSB +: 2] <= cfg.org;
      end else if (paddr == TIM_OFS) begin
        prdata_r[TRAS_LSB +: CNT_W] <= cfg.tras;
        prdata_r[TRTP_LSB +: CNT_W] <= cfg.trtp;
      end else if (paddr == STAT_OFS) begin
        prdata_r <= status;
      end
    end
  end
endmodule : ddr2_regs

// ### design/ddr2_bank.sv
// one bank: open state, restore and read-to-precharge timers, auto-precharge
// assumes commands are already decoded and steered to this bank
`timescale 1ns/1ns
module ddr2_bank (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // decoded commands for this bank
  input wire logic act,
  input wire logic rd,
  input wire logic wr,
  input wire logic ap,
  input wire logic pre,
  // timing from configuration
  input wire logic [ddr2_pkg::CNT_W-1:0] tras,
  input wire logic [ddr2_pkg::CNT_W-1:0] trtp,
  input wire logic [ddr2_pkg::CNT_W-1:0] rd_gap,
  input wire logic [ddr2_pkg::CNT_W-1:0] wr_gap,
  // state
  output logic open_r,
  output logic ap_pend_r,
  output logic ap_fire
);
  import ddr2_pkg::*;

  logic [CNT_W-1:0] tras_cnt_r;
  logic [CNT_W-1:0] rtp_cnt_r;
  logic [CNT_W-1:0] ap_cnt_r;
  logic [CNT_W-1:0] gap_r;
  logic [CNT_W-1:0] since_cmd_r;
  logic [CNT_W-1:0] since_act_r;

  // a count at one or below means its delay has run out at this edge
  assign ap_fire = ap_pend_r && ap_cnt_r <= CNT_ONE && tras_cnt_r <= CNT_ONE && rtp_cnt_r <= CNT_ONE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) open_r <= 1'b0;
    else if (act) open_r <= 1'b1;
    else if (pre || ap_fire) open_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tras_cnt_r <= '0;
      rtp_cnt_r <= '0;
    end else begin
      if (act) tras_cnt_r <= tras;
      else if (tras_cnt_r != '0) tras_cnt_r <= tras_cnt_r - CNT_ONE;
      if (rd) rtp_cnt_r <= trtp;
      else if (rtp_cnt_r != '0) rtp_cnt_r <= rtp_cnt_r - CNT_ONE;
    end
  end

  // the gap is taken from the programmed burst, so a shortened burst changes nothing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ap_pend_r <= 1'b0;
      ap_cnt_r <= '0;
      gap_r <= '0;
    end else if ((rd || wr) && ap) begin
      ap_pend_r <= 1'b1;
      ap_cnt_r <= rd ? rd_gap : wr_gap;
      gap_r <= rd ? rd_gap : wr_gap;
    end else if (ap_fire || pre) begin
      ap_pend_r <= 1'b0;
    end else if (ap_cnt_r != '0) begin
      ap_cnt_r <= ap_cnt_r - CNT_ONE;
    end
  end

  // elapsed-cycle counters read only by the checks below
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since_cmd_r <= '0;
      since_act_r <= '0;
    end else begin
      if (rd || wr) since_cmd_r <= CNT_ONE;
      else if (since_cmd_r != CNT_MAX) since_cmd_r <= since_cmd_r + CNT_ONE;
      if (act) since_act_r <= CNT_ONE;
      else if (since_act_r != CNT_MAX) since_act_r <= since_act_r + CNT_ONE;
    end
  end

  ap_not_early_a: assert property (@(posedge clk) disable iff (!arst_n) ap_fire |-> since_cmd_r >= gap_r)
    else $error("auto precharge started before its burst gap");
  ap_tras_a: assert property (@(posedge clk) disable iff (!arst_n) ap_fire |-> since_act_r >= tras)
    else $error("auto precharge started before restore time");
  pre_close_a: assert property (@(posedge clk) disable iff (!arst_n) pre && !act |=> !open_r)
    else $error("bank still open after precharge");
endmodule : ddr2_bank

// ### design/ddr2_core.sv
// command and data-path core of the memory device, registers over apb
// assumes synchronous command pins; two data beats per clock on wdq and wdm
`timescale 1ns/1ns
module ddr2_core #(
  parameter int DQ_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command pins
  input ddr2_pkg::cmd_pins_s cmd,
  // write data: beat 0 in low half, beat 1 in high half; two mask lanes per beat
  input wire logic [2*DQ_W-1:0] wdq,
  input wire logic [3:0] wdm,
  // array write port
  output logic arr_we_r,
  output logic [ddr2_pkg::BA_W-1:0] arr_bank_r,
  output logic [ddr2_pkg::COL_W-1:0] arr_col_r,
  output logic [2*DQ_W-1:0] arr_data_r,
  output logic [2*DQ_W-1:0] arr_keep_r,
  // read beat strobe
  output logic rd_beat_r,
  output logic [ddr2_pkg::BA_W-1:0] rd_bank_r,
  output logic [ddr2_pkg::COL_W-1:0] rd_col_r,
  // bank state
  output logic [ddr2_pkg::BANKS-1:0] bank_open
);
  import ddr2_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WBURST = 3'h2,
    ST_RBURST = 3'h4
  } burst_e;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [CNT_W-1:0] half_burst(input logic bl8);
    return bl8 ? CNT_W'(4) : CNT_W'(2);
  endfunction : half_burst

  function automatic logic [CNT_W-1:0] lat_sum(input logic [2:0] a, input logic [2:0] b);
    return CNT_W'({3'h0, a}) + CNT_W'({3'h0, b});
  endfunction : lat_sum

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  cfg_s cfg;
  logic [31:0] status;
  logic err_clr;
  logic [BANKS-1:0] ap_pend;
  logic [BANKS-1:0] ap_fire;
  logic err_r;
  burst_e state_r;
  logic busy;

  ddr2_regs u_regs (
    .clk(clk),
    .arst_n(arst_n),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg),
    .status(status),
    .err_clr(err_clr)
  );

  assign busy = (state_r != ST_IDLE);

  always_comb begin
    status = 32'h0;
    status[OPEN_LSB +: BANKS] = bank_open;
    status[APP_LSB +: BANKS] = ap_pend;
    status[BUSY_BIT] = busy;
    status[ERR_BIT] = err_r;
  end

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  logic sel;
  logic is_act;
  logic is_rd;
  logic is_wr;
  logic is_pre;
  logic a10;
  logic [CNT_W-1:0] blh;
  logic [CNT_W-1:0] rl;
  logic [CNT_W-1:0] wl;
  logic [CNT_W-1:0] rd_gap;
  logic [CNT_W-1:0] wr_gap;

  assign sel = !cmd.cs_n;
  assign is_act = sel && !cmd.ras_n && cmd.cas_n && cmd.we_n;
  assign is_rd = sel && cmd.ras_n && !cmd.cas_n && cmd.we_n;
  assign is_wr = sel && cmd.ras_n && !cmd.cas_n && !cmd.we_n;
  assign is_pre = sel && !cmd.ras_n && cmd.cas_n && !cmd.we_n;
  assign a10 = cmd.addr[AP_BIT];

  assign blh = half_burst(cfg.bl8);
  assign rl = lat_sum(cfg.al, cfg.cl);
  assign wl = rl - CNT_ONE;
  // the read gap ends two clocks after the last prefetch for either length
  assign rd_gap = lat_sum(cfg.al, 3'h0) + blh;
  assign wr_gap = wl + blh + lat_sum(cfg.wr, 3'h0);

  // ----------------------------------------------------------------------
  // banks
  // ----------------------------------------------------------------------
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    logic hit;
    assign hit = (cmd.ba == BA_W'(b));
    ddr2_bank u_bank (
      .clk(clk),
      .arst_n(arst_n),
      .act(is_act && hit),
      .rd(is_rd && hit),
      .wr(is_wr && hit),
      .ap(a10),
      .pre(is_pre && (a10 || hit)),
      .tras(cfg.tras),
      .trtp(cfg.trtp),
      .rd_gap(rd_gap),
      .wr_gap(wr_gap),
      .open_r(bank_open[b]),
      .ap_pend_r(ap_pend[b]),
      .ap_fire(ap_fire[b])
    );
  end

  // ----------------------------------------------------------------------
  // latency line: entry k holds the column command issued k+1 clocks ago
  // ----------------------------------------------------------------------
  burst_s pipe_r [LAT_MAX];
  burst_s tap;
  burst_s cur_r;
  logic [CNT_W-1:0] beats_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < LAT_MAX; i++) pipe_r[i] <= '0;
    end else begin
      pipe_r[0] <= '{valid: is_rd || is_wr, is_wr: is_wr, bank: cmd.ba, col: cmd.addr[COL_W-1:0]};
      for (int i = 1; i < LAT_MAX; i++) pipe_r[i] <= pipe_r[i-1];
    end
  end

  always_comb begin
    tap = '0;
    for (int i = 0; i < LAT_MAX; i++) begin
      if (CNT_W'(i) == wl - CNT_ONE && pipe_r[i].valid && pipe_r[i].is_wr) tap = pipe_r[i];
      if (CNT_W'(i) == rl - CNT_ONE && pipe_r[i].valid && !pipe_r[i].is_wr) tap = pipe_r[i];
    end
  end

  // ----------------------------------------------------------------------
  // burst sequencer: a new start always restarts the count, which gives both
  // seamless streaming and the two-clock interruption
  // ----------------------------------------------------------------------
  logic start;
  logic active_wr;
  logic active_rd;
  logic [COL_W-1:0] beat_col;

  assign start = tap.valid;
  assign active_wr = start ? tap.is_wr : (state_r == ST_WBURST);
  assign active_rd = start ? !tap.is_wr : (state_r == ST_RBURST);
  assign beat_col = start ? tap.col : cur_r.col;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      beats_r <= '0;
      cur_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE, ST_WBURST, ST_RBURST: begin
          if (start) begin
            state_r <= tap.is_wr ? ST_WBURST : ST_RBURST;
            beats_r <= blh - CNT_ONE;
            cur_r <= tap;
            cur_r.col <= tap.col + COL_W'(2);
          end else if (beats_r > CNT_ONE) begin
            beats_r <= beats_r - CNT_ONE;
            cur_r.col <= cur_r.col + COL_W'(2);
          end else begin
            beats_r <= '0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          beats_r <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // write masking
  // ----------------------------------------------------------------------
  logic mask_off;
  logic [2*DQ_W-1:0] keep;

  assign mask_off = cfg.rdqs_en && (cfg.org == ORG_X8);

  // x16 uses a lane per byte; narrower parts apply lane 0 to the whole beat, except x8 with rdqs_en, which keeps every bit
  always_comb begin
    keep = '1;
    for (int beat = 0; beat < 2; beat++) begin
      for (int bit_i = 0; bit_i < DQ_W; bit_i++) begin
        if (!mask_off) begin
          if (cfg.org == ORG_X16)
            keep[beat*DQ_W+bit_i] = !wdm[beat*2 + ((bit_i >= DQ_W/2) ? 1 : 0)];
          else
            keep[beat*DQ_W+bit_i] = !wdm[beat*2];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arr_we_r <= 1'b0;
      arr_bank_r <= '0;
      arr_col_r <= '0;
      arr_data_r <= '0;
      arr_keep_r <= '0;
    end else begin
      arr_we_r <= active_wr;
      if (active_wr) begin
        arr_bank_r <= start ? tap.bank : cur_r.bank;
        arr_col_r <= beat_col;
        arr_data_r <= wdq;
        arr_keep_r <= keep;
      end
    end
  end

  // read beats carry no mask: the mask pins are not looked at here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_beat_r <= 1'b0;
      rd_bank_r <= '0;
      rd_col_r <= '0;
    end else begin
      rd_beat_r <= active_rd;
      if (active_rd) begin
        rd_bank_r <= start ? tap.bank : cur_r.bank;
        rd_col_r <= beat_col;
      end
    end
  end

  // ----------------------------------------------------------------------
  // protocol watch: sticky flag for interruptions the controller must avoid
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] since_col_r;
  logic last_wr_r;
  logic last_ap_r;
  logic bad_cmd;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since_col_r <= CNT_MAX;
      last_wr_r <= 1'b0;
      last_ap_r <= 1'b0;
    end else if (is_rd || is_wr) begin
      since_col_r <= CNT_ONE;
      last_wr_r <= is_wr;
      last_ap_r <= a10;
    end else if (since_col_r != CNT_MAX) begin
      since_col_r <= since_col_r + CNT_ONE;
    end
  end

  // a precharge or column command inside the previous command's half burst, unless a length-8 same-direction column two clocks after one with a10 low
  always_comb begin
    bad_cmd = 1'b0;
    if (since_col_r < blh) begin
      if (is_rd || is_wr)
        bad_cmd = !cfg.bl8 || last_ap_r || (is_wr != last_wr_r) || (since_col_r != CNT_W'(2));
      if (is_pre)
        bad_cmd = 1'b1;
    end
  end

  // a new violation in the clearing cycle keeps the flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) err_r <= 1'b0;
    else if (bad_cmd) err_r <= 1'b1;
    else if (err_clr) err_r <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  pre_all_a: assert property (@(posedge clk) disable iff (!arst_n) is_pre && a10 && !is_act |=> bank_open == '0)
    else $error("precharge all left a bank open");
  pre_one_a: assert property (@(posedge clk) disable iff (!arst_n)
    is_pre && !a10 |=> !bank_open[$past(cmd.ba)])
    else $error("single bank precharge missed its bank");
  rd_nomask_a: assert property (@(posedge clk) disable iff (!arst_n) rd_beat_r |-> !arr_we_r)
    else $error("array written during a read burst");
  dm_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    arr_we_r && $past(mask_off) |-> arr_keep_r == '1)
    else $error("mask applied while redundant strobe enabled");
  wr_lat_a: assert property (@(posedge clk) disable iff (!arst_n)
    is_wr && cfg.al == 3'h0 && cfg.cl == 3'h3 |-> ##3 arr_we_r)
    else $error("write data not taken at write latency");
  rd_lat_a: assert property (@(posedge clk) disable iff (!arst_n)
    is_rd && cfg.al == 3'h0 && cfg.cl == 3'h3 |-> ##4 rd_beat_r)
    else $error("read beat not at read latency");
  bl8_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arr_we_r) && cfg.bl8 |-> arr_we_r [*4])
    else $error("length-8 write burst shorter than four clocks");
  mask_lane_a: assert property (@(posedge clk) disable iff (!arst_n)
    active_wr && !mask_off && cfg.org == ORG_X16 && wdm[0] |=> arr_keep_r[DQ_W/2-1:0] == '0)
    else $error("masked lower lane beat was kept");
  err_set_a: assert property (@(posedge clk) disable iff (!arst_n) bad_cmd |=> err_r)
    else $error("illegal interruption not flagged");
endmodule : ddr2_core

// ### tb/ddr2_ctl_model.sv
// controller stand-in driving command pins and write beats
// assumes the bench arms it between rising edges
`timescale 1ns/1ns
module ddr2_ctl_model (
  // clock
  input wire logic clk,
  // pins toward the core
  output ddr2_pkg::cmd_pins_s cmd,
  output logic [31:0] wdq,
  output logic [3:0] wdm
);
  import ddr2_pkg::*;
  cmd_pins_s cc;
  logic [35:0] dd;
  logic cv = 0;
  logic dv = 0;
  initial begin
    cmd = '1;
    {wdm, wdq} = '0;
  end
  // idle lines other than cs_n, which stays high, flip each cycle so stale values never pass for live ones
  always @(posedge clk) begin
    cmd <= cv ? cc : cmd_pins_s'({1'b1, ~cmd[19:0]});
    {wdm, wdq} <= dv ? dd : ~{wdm, wdq};
    cv = 0;
    dv = 0;
  end
  // spacing limits are kept by whoever arms the commands
  task arm_cmd(input logic [2:0] rcw, input logic [2:0] ba, input logic [13:0] a);
    cc = {1'b0, rcw, ba, a};
    cv = 1;
  endtask : arm_cmd
  task arm_beat(input logic [31:0] d, input logic [3:0] m);
    dd = {m, d};
    dv = 1;
  endtask : arm_beat
endmodule : ddr2_ctl_model

// ### tb/ddr2_mask_interrupt_precharge_bench.sv
// bench for the command core: apb, masked and streamed writes, precharge
// assumes the core's reset configuration and the controller stand-in
`timescale 1ns/1ns
module ddr2_mask_interrupt_precharge_bench;
  import ddr2_pkg::*;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, arr_we_r, rd_beat_r;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, arr_data_r, arr_keep_r, wdq, seed = 32'hd, d[2];
  logic [3:0] wdm, m[2];
  logic [2:0] b, arr_bank_r, rd_bank_r;
  logic [9:0] arr_col_r, rd_col_r;
  logic [1:0] o;
  logic [7:0] bank_open;
  cmd_pins_s cmd;
  int t = 0, base = 0, mismatches = 0, total_checks = 0;
  ddr2_core u_dut (.clk, .arst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .cmd, .wdq, .wdm, .arr_we_r, .arr_bank_r, .arr_col_r, .arr_data_r, .arr_keep_r, .rd_beat_r,
    .rd_bank_r, .rd_col_r, .bank_open);
  ddr2_ctl_model u_ctl (.clk, .cmd, .wdq, .wdm);
  always #25 clk = ~clk;
  always @(posedge clk) t <= t + 1;
  always @(posedge clk) if (t == 3000) begin
    mismatches++;
    print_verdict();
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] cfgv(input logic [2:0] al, input logic bl8, input logic rq, input logic [1:0] g);
    return {19'h0, g, rq, 3'h3, bl8, al, 3'h3};
  endfunction : cfgv
  function automatic logic [31:0] keep(input logic [3:0] k, input logic [1:0] g, input logic rq);
    if (g == ORG_X16) return ~{{8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}};
    if (g == ORG_X8 && rq) return '1;
    return ~{{16{k[2]}}, {16{k[0]}}};
  endfunction : keep
  task chk(input logic ok, input string s);
    total_checks++;
    if (!ok) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, s);
    end
  endtask : chk
  task tick();
    @(posedge clk);
    @(negedge clk);
  endtask : tick
  task at(input int k);
    while (t < base + k) @(negedge clk);
  endtask : at
  task go(input logic [2:0] rcw, input logic [2:0] bk, input logic [13:0] a);
    u_ctl.arm_cmd(rcw, bk, a);
    tick();
    base = t;
  endtask : go
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(negedge clk);
  endtask : apb
  task print_verdict();
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1;
    apb(0, CFG_OFS, 0);
    chk(rd === cfgv(0, 0, 0, ORG_X16), "cfg reset");
    apb(0, TIM_OFS, 0);
    chk(rd === 32'h101, "tim reset");
    apb(0, 12'h00c, 0);
    chk(er === 1'b1, "unmapped");
    for (int i = 0; i < 8; i++) begin
      go(3'b011, 3'(i), 0);
      tick();
      chk(bank_open === 8'hff >> (7 - i), "activate");
    end
    b = 3'(rnd());
    go(3'b010, b, 0);
    tick();
    chk(bank_open === ~(8'h1 << b), "bank close");
    go(3'b010, ~b, 14'h400);
    tick();
    chk(bank_open === 8'h0, "close all");
    for (int i = 0; i < 4; i++) begin
      o = i == 0 ? ORG_X16 : i < 3 ? ORG_X8 : ORG_X4;
      apb(1, CFG_OFS, cfgv(0, 0, i[0], o));
      b = 3'(rnd());
      go(3'b011, b, 0);
      go(3'b100, b, {4'h1, 10'(rnd())});
      tick();
      for (int k = 0; k < 4; k++) begin
        if (k < 2) begin
          d[k] = rnd();
          m[k] = 4'(rnd());
          u_ctl.arm_beat(d[k], m[k]);
        end
        tick();
        if (k == 3) chk(arr_we_r === 1'b0, "write end");
        else if (k > 0) begin
          chk(arr_we_r === 1'b1 && arr_bank_r === b && arr_keep_r === keep(m[k-1], o, i[0]), "mask");
          chk(((arr_data_r ^ d[k-1]) & arr_keep_r) === '0, "write data");
        end
      end
      at(7);
      chk(bank_open[b] === 1'b1, "write ap early");
      at(8);
      chk(bank_open[b] === 1'b0, "write ap close");
    end
    for (int al = 0; al < 3; al++) begin
      apb(1, CFG_OFS, cfgv(3'(al), 0, 0, ORG_X16));
      b = 3'(rnd());
      go(3'b011, b, 0);
      go(3'b101, b, 14'h400);
      at(al + 2);
      chk(bank_open[b] === 1'b1 && arr_we_r === 1'b0, "read ap early");
      at(al + 3);
      chk(bank_open[b] === 1'b0 && rd_beat_r === 1'b0, "read ap close");
      at(al + 4);
      chk(rd_beat_r === 1'b1 && rd_bank_r === b && rd_col_r === 10'h0, "read latency");
    end
    for (int bl = 0; bl < 2; bl++) begin
      apb(1, CFG_OFS, cfgv(0, bl[0], 0, ORG_X16));
      go(3'b011, 3'h2, 0);
      go(3'b011, 3'h5, 0);
      go(3'b100, 3'h2, 0);
      for (int c = 1; c < 10; c++) begin
        if (c == 2) u_ctl.arm_cmd(3'b100, 3'h5, 14'h8);
        if (c > 1 && c < 6 + 2 * bl) u_ctl.arm_beat(rnd(), 4'h0);
        tick();
        if (c > 2) chk(arr_we_r === (c < 7 + 2 * bl), "stream");
        if (c > 2 && c < 7) chk(arr_bank_r === (c < 5 ? 3'h2 : 3'h5) && arr_col_r === 10'(c < 5 ? 2 * c - 6 : 2 * c - 2),
          "stream bank");
      end
    end
    // a precharge one clock into a length-8 read must raise the sticky flag
    go(3'b101, 3'h2, 0);
    go(3'b010, 3'h2, 0);
    apb(0, STAT_OFS, 0);
    chk(rd[ERR_BIT] === 1'b1 && rd[15:0] === 16'h0020, "early precharge flag");
    apb(1, STAT_OFS, 32'h00020000);
    apb(0, STAT_OFS, 0);
    chk(rd[ERR_BIT] === 1'b0, "flag clear");
    print_verdict();
  end
endmodule : ddr2_mask_interrupt_precharge_bench
